//--- bsbs_top.sv
// Secondary bus status register with sticky event flags
`timescale 1ns/1ps
`default_nettype none
module bsbs_top (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Configuration access
    input wire bsbs_pkg::bsbs_cfg_t cfg_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    // Secondary bus events
    input wire bsbs_pkg::bsbs_event_t ev_in,
    input wire logic parity_response_enable_in,
    // Live status
    output logic [15:0] status_out
);
    import bsbs_pkg::*;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    wire hit;
    wire [BSBS_NUM_FLAGS-1:0] set_vec;
    wire [BSBS_NUM_FLAGS-1:0] clr_vec;
    wire [BSBS_NUM_FLAGS-1:0] flag_vec;
    wire [15:0] status_word;
    wire [15:0] clr_word;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic [15:0] status_reg;

    assign hit = cfg_in.addr == BSBS_STATUS_OFFSET;
    // Byte enables gate which halves a write may clear
    assign clr_word = {cfg_in.be[1] ? cfg_in.wdata[15:8] : 8'h00,
        cfg_in.be[0] ? cfg_in.wdata[7:0] : 8'h00}
        & {16{cfg_in.wr & hit}} & BSBS_FLAG_MASK;
    assign clr_vec = {clr_word[BSBS_PAR_BIT], clr_word[BSBS_SERR_BIT],
        clr_word[BSBS_RECEIVED_MASTER_ABORT_FLAG_BIT], clr_word[BSBS_RECEIVED_TARGET_ABORT_FLAG_BIT],
        clr_word[BSBS_SIGNALED_TARGET_ABORT_FLAG_BIT], clr_word[BSBS_MPAR_BIT]};

    bsbs_event_decode u_dec (
        .ev_in(ev_in),
        .parity_response_enable_in(parity_response_enable_in),
        .set_out(set_vec)
    );

    genvar gi;
    generate
        for (gi = 0; gi < BSBS_NUM_FLAGS; gi++)
        begin : g_flag
            bsbs_flag u_flag (
                .core_clk_in(core_clk_in),
                .rst_n_in(rst_n_in),
                .set_in(set_vec[gi]),
                .clear_in(clr_vec[gi]),
                .flag_out(flag_vec[gi])
            );
        end
    endgenerate

    // Fixed bits are constants, so writes cannot reach them
    assign status_word = BSBS_FIXED_BITS
        | {flag_vec[5], flag_vec[4], flag_vec[3], flag_vec[2],
           flag_vec[1], 2'b00, flag_vec[0], 8'h00};

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            status_reg <= BSBS_FIXED_BITS;
        end
        else
        begin
            rdata_reg <= (cfg_in.rd & hit) ? status_word : 16'h0000;
            rvalid_reg <= cfg_in.rd;
            status_reg <= status_word;
        end
    end

    assign rdata_out = rdata_reg;
    assign rvalid_out = rvalid_reg;
    assign status_out = status_reg;

    fixed_bits_a: assert property (
        (status_out & ~BSBS_FLAG_MASK) == BSBS_FIXED_BITS)
        else $error("fixed bits wrong");
    timing_field_a: assert property (
        status_out[BSBS_TIMING_LO_BIT +: 2] == BSBS_TIMING_VAL)
        else $error("timing field not 01");
    fbb_bit_a: assert property (
        status_out[BSBS_FBB_BIT] && status_out[BSBS_HS_BIT])
        else $error("capability bit low");
    reserved_zero_a: assert property (
        status_out[6] == 1'b0 && status_out[4:0] == 5'h00)
        else $error("reserved bits set");
    par_set_a: assert property (
        (ev_in.addr_attr_err | ev_in.write_data_err | ev_in.read_data_err)
        |-> ##2 status_out[BSBS_PAR_BIT])
        else $error("parity flag not set");
    serr_set_a: assert property (
        ev_in.serr_seen |-> ##2 status_out[BSBS_SERR_BIT])
        else $error("system error flag not set");
    received_master_abort_flag_set_a: assert property (
        ev_in.master_abort |-> ##2 status_out[BSBS_RECEIVED_MASTER_ABORT_FLAG_BIT])
        else $error("master abort flag not set");
    trec_set_a: assert property (
        ev_in.target_abort_rcvd |-> ##2 status_out[BSBS_RECEIVED_TARGET_ABORT_FLAG_BIT])
        else $error("received target abort flag not set");
    tsig_set_a: assert property (
        ev_in.target_abort_sent |-> ##2 status_out[BSBS_SIGNALED_TARGET_ABORT_FLAG_BIT])
        else $error("signaled target abort flag not set");
    mpar_set_a: assert property (
        ev_in.is_master && parity_response_enable_in
        && (ev_in.perr_on_read || ev_in.perr_on_write)
        |-> ##2 status_out[BSBS_MPAR_BIT])
        else $error("master parity flag not set");
    mpar_gate_a: assert property (
        $rose(flag_vec[0]) |-> $past(ev_in.is_master)
        && $past(parity_response_enable_in)
        && ($past(ev_in.perr_on_read) || $past(ev_in.perr_on_write)))
        else $error("master parity flag set without cause");
    flag_sticky_a: assert property (
        $fell(flag_vec[5]) |-> $past(clr_vec[5]))
        else $error("flag dropped without clear");
endmodule
`default_nettype wire

//--- bsbs_pkg.sv
// Package for the secondary bus status register bank
package bsbs_pkg;
    localparam logic [7:0] BSBS_STATUS_OFFSET = 8'h1e;
    localparam int BSBS_PAR_BIT = 15;
    localparam int BSBS_SERR_BIT = 14;
    localparam int BSBS_RECEIVED_MASTER_ABORT_FLAG_BIT = 13;
    localparam int BSBS_RECEIVED_TARGET_ABORT_FLAG_BIT = 12;
    localparam int BSBS_SIGNALED_TARGET_ABORT_FLAG_BIT = 11;
    localparam int BSBS_TIMING_LO_BIT = 9;
    localparam int BSBS_MPAR_BIT = 8;
    localparam int BSBS_FBB_BIT = 7;
    localparam int BSBS_HS_BIT = 5;
    localparam int BSBS_NUM_FLAGS = 6;
    localparam logic [1:0] BSBS_TIMING_VAL = 2'h1;
    localparam logic [BSBS_NUM_FLAGS-1:0] BSBS_FLAGS_RESET = 6'h00;
    localparam logic [15:0] BSBS_FIXED_BITS = 16'h02a0;
    localparam logic [15:0] BSBS_FLAG_MASK = 16'hf900;

    // Bus events seen on the secondary interface, one-cycle pulses
    typedef struct packed {
        logic addr_attr_err;
        logic write_data_err;
        logic read_data_err;
        logic serr_seen;
        logic master_abort;
        logic target_abort_rcvd;
        logic target_abort_sent;
        logic is_master;
        logic perr_on_read;
        logic perr_on_write;
    } bsbs_event_t;

    // Configuration access to the status register
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } bsbs_cfg_t;
endpackage

//--- bsbs_flag.sv
// One sticky write-one-to-clear status flag
`timescale 1ns/1ps
`default_nettype none
module bsbs_flag (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Set and clear
    input wire logic set_in,
    input wire logic clear_in,
    // State
    output logic flag_out
);
    logic flag_reg;
    logic flag_next;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Set wins so an event in the clearing cycle is not lost
    assign flag_next = set_in | (flag_reg & ~clear_in);
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end
    assign flag_out = flag_reg;

    set_wins_a: assert property (
        set_in |=> flag_out)
        else $error("flag not set by event");
    flag_hold_a: assert property (
        flag_out && !clear_in |=> flag_out)
        else $error("flag dropped without clear");
    clear_one_a: assert property (
        clear_in && !set_in |=> !flag_out)
        else $error("flag not cleared by write");
endmodule
`default_nettype wire

//--- bsbs_event_decode.sv
// Decodes secondary bus events into flag set strobes
`timescale 1ns/1ps
`default_nettype none
module bsbs_event_decode (
    // Events and control
    input wire bsbs_pkg::bsbs_event_t ev_in,
    input wire logic parity_response_enable_in,
    // Set strobes, bit order par, serr, received_master_abort_flag, trec, tsig, mpar
    output logic [bsbs_pkg::BSBS_NUM_FLAGS-1:0] set_out
);
    import bsbs_pkg::*;
    wire par_set;
    wire mpar_set;
    // Parity enable is deliberately absent here
    assign par_set = ev_in.addr_attr_err
        | ev_in.write_data_err
        | ev_in.read_data_err;
    assign mpar_set = ev_in.is_master & parity_response_enable_in
        & (ev_in.perr_on_read | ev_in.perr_on_write);
    assign set_out = {par_set,
        ev_in.serr_seen,
        ev_in.master_abort,
        ev_in.target_abort_rcvd,
        ev_in.target_abort_sent,
        mpar_set};
endmodule
`default_nettype wire

//--- bsbs_pci_model.sv
// Behavioural model of the internal PCI bus raising secondary events
`timescale 1ns/1ps
`default_nettype none
module bsbs_pci_model (
    // Clock
    input wire logic core_clk_in,
    // Events and enable towards the status block
    output var bsbs_pkg::bsbs_event_t ev_out,
    output var logic parity_response_enable_out
);
    import bsbs_pkg::*;
    initial
    begin
        ev_out = '0;
        parity_response_enable_out = 1'b0;
    end
    // Events are one-cycle pulses; the enable stays as a level afterwards
    task automatic fire(input logic [9:0] v, input logic pe);
        @(posedge core_clk_in) #1;
        ev_out = bsbs_event_t'(v);
        parity_response_enable_out = pe;
        @(posedge core_clk_in) #1;
        ev_out = '0;
    endtask
endmodule
`default_nettype wire

//--- test_bridge_secondary_bus_status.sv
// Self-checking bench for the secondary bus status register
`timescale 1ns/1ps
`default_nettype none
module test_bridge_secondary_bus_status;
    import bsbs_pkg::*;
    // Timing field 01b, back-to-back and high-speed bits set
    localparam logic [15:0] FIX = 16'h02a0;
    logic core_clk_in;
    logic rst_n_in;
    bsbs_cfg_t cfg;
    bsbs_event_t ev;
    logic pe;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] status;
    int n_fail = 0;
    int samples_checked = 0;
    bsbs_top u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .cfg_in(cfg), .rdata_out(rdata), .rvalid_out(rvalid), .ev_in(ev),
        .parity_response_enable_in(pe), .status_out(status));
    bsbs_pci_model u_pci (.core_clk_in(core_clk_in), .ev_out(ev),
        .parity_response_enable_out(pe));
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [1:0] b,
        input logic [15:0] d);
        @(posedge core_clk_in) #1;
        cfg = {1'b0, 1'b1, a, b, d};
        @(posedge core_clk_in) #1;
        cfg = '0;
    endtask
    // Answer is due exactly one cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk_in) #1;
        cfg = {1'b1, 1'b0, a, 2'b00, 16'h0000};
        @(posedge core_clk_in) #1;
        cfg = '0;
        chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata, exp);
        // Valid stands for one cycle only
        @(posedge core_clk_in) #1;
        chk({15'h0000, rvalid}, 16'h0000);
    endtask
    task automatic t_reset;
        chk(status, FIX);
        rd(8'h1e, FIX);
        $display("reset test done");
    endtask
    // Fire, see the flag live and by read, clear it with a one
    task automatic t_ev(input logic [9:0] v, input logic p,
        input logic [15:0] f);
        u_pci.fire(v, p);
        @(posedge core_clk_in) #1;
        chk(status, FIX | f);
        rd(8'h1e, FIX | f);
        wr(8'h1e, 2'b11, f);
        rd(8'h1e, FIX);
        $display("event test %h done", v);
    endtask
    task automatic t_sticky;
        u_pci.fire(10'h040, 1'b0);
        wr(8'h1e, 2'b11, 16'h0000);
        rd(8'h1e, FIX | 16'h4000);
        wr(8'h20, 2'b11, 16'hffff);
        rd(8'h1e, FIX | 16'h4000);
        wr(8'h1e, 2'b01, 16'h4000);
        rd(8'h1e, FIX | 16'h4000);
        wr(8'h1e, 2'b11, 16'h46ff);
        rd(8'h1e, FIX);
        rd(8'h20, 16'h0000);
        u_pci.fire(10'h020, 1'b0);
        @(posedge core_clk_in) #1;
        chk(status, FIX | 16'h2000);
        rst_n_in = 1'b0;
        @(posedge core_clk_in) #1;
        rst_n_in = 1'b1;
        chk(status, FIX);
        rd(8'h1e, FIX);
        $display("sticky test done");
    endtask
    // Event and write-one clear on the same edge: the event must win
    task automatic t_race;
        fork
            u_pci.fire(10'h040, 1'b0);
            wr(8'h1e, 2'b11, 16'h4000);
        join
        rd(8'h1e, FIX | 16'h4000);
        wr(8'h1e, 2'b11, 16'h4000);
        rd(8'h1e, FIX);
        $display("race test done");
    endtask
    initial
    begin
        rst_n_in = 1'b0;
        cfg = '0;
        repeat (6) @(posedge core_clk_in);
        #1 rst_n_in = 1'b1;
        t_reset;
        t_ev(10'h200, 1'b0, 16'h8000);
        t_ev(10'h100, 1'b0, 16'h8000);
        t_ev(10'h084, 1'b1, 16'h8000);
        t_ev(10'h040, 1'b0, 16'h4000);
        t_ev(10'h024, 1'b0, 16'h2000);
        t_ev(10'h010, 1'b0, 16'h1000);
        t_ev(10'h008, 1'b0, 16'h0800);
        t_ev(10'h006, 1'b1, 16'h0100);
        t_ev(10'h005, 1'b1, 16'h0100);
        t_ev(10'h006, 1'b0, 16'h0000);
        t_ev(10'h002, 1'b1, 16'h0000);
        t_sticky;
        t_race;
        stop_test;
    end
    // Hang guard
    initial
    begin
        repeat (5000) @(posedge core_clk_in);
        n_fail++;
        stop_test;
    end
endmodule
`default_nettype wire
